// ### core/bmrs_pkg.sv
// constants and types shared by the battery monitor and reset supervisor
package bmrs_pkg;
	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned BATT_TIMEOUT_MS = 150;
	localparam int unsigned SHORT_RST_MS    = 150;
	localparam int unsigned LONG_RST_MS     = 1200;
	localparam int unsigned MR_PULSE_MS     = 150;
	localparam int unsigned DEBOUNCE_MS     = 20;
	// least times round up to whole cycles
	localparam longint unsigned BATT_TIMEOUT_CYC =
		(longint'(BATT_TIMEOUT_MS) * CLK_HZ + 999) / 1000;
	localparam longint unsigned SHORT_RST_CYC =
		(longint'(SHORT_RST_MS) * CLK_HZ + 999) / 1000;
	localparam longint unsigned LONG_RST_CYC =
		(longint'(LONG_RST_MS) * CLK_HZ + 999) / 1000;
	localparam longint unsigned MR_PULSE_CYC =
		(longint'(MR_PULSE_MS) * CLK_HZ + 999) / 1000;
	localparam longint unsigned DEBOUNCE_CYC =
		(longint'(DEBOUNCE_MS) * CLK_HZ + 999) / 1000;
	localparam int CNT_W = 32;

	// ==========================================================
	// build options and supply supervisor states
	typedef enum logic {BMRS_SINGLE, BMRS_DUAL} bmrs_variant_type;
	typedef enum logic {BMRS_SHORT_TIMEOUT, BMRS_LONG_TIMEOUT} bmrs_timeout_type;
	typedef enum logic [1:0] {BMRS_PWR_LOW, BMRS_PWR_WAIT, BMRS_PWR_OK} bmrs_pwr_type;
endpackage : bmrs_pkg

// ### core/bmrs_top.sv
// battery monitor flags and supervisor reset timing
`timescale 1ns/1ps
module bmrs_top
	import bmrs_pkg::*;
#(
	parameter bmrs_pkg::bmrs_variant_type VARIANT        = bmrs_pkg::BMRS_DUAL,
	parameter bmrs_pkg::bmrs_timeout_type TIMEOUT_OPTION = bmrs_pkg::BMRS_SHORT_TIMEOUT,
	parameter longint unsigned            BATT_CYC       = bmrs_pkg::BATT_TIMEOUT_CYC,
	parameter longint unsigned            SHORT_CYC      = bmrs_pkg::SHORT_RST_CYC,
	parameter longint unsigned            LONG_CYC       = bmrs_pkg::LONG_RST_CYC,
	parameter longint unsigned            MR_CYC         = bmrs_pkg::MR_PULSE_CYC,
	parameter longint unsigned            DEB_CYC        = bmrs_pkg::DEBOUNCE_CYC
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic low_level_sense_in,
	input  wire logic high_level_sense_in,
	input  wire logic supply_ok_in,
	input  wire logic manual_rst_n,
	output logic      combined_low_batt_flag_n,
	output logic      weak_batt_flag_n,
	output logic      empty_batt_flag_n,
	output logic      host_rst_n
);
	import bmrs_pkg::*;

	localparam logic [CNT_W-1:0] BATT_LAST = CNT_W'(BATT_CYC - 1);
	localparam logic [CNT_W-1:0] RST_LAST  =
		CNT_W'(((TIMEOUT_OPTION == BMRS_LONG_TIMEOUT) ? LONG_CYC : SHORT_CYC) - 1);
	localparam logic [CNT_W-1:0] MR_LAST   = CNT_W'(MR_CYC - 1);
	localparam logic [CNT_W-1:0] DEB_LAST  = CNT_W'(DEB_CYC - 1);

	// ==========================================================
	// input synchronisers
	logic [1:0] lo_s_r;
	logic [1:0] hi_s_r;
	logic [1:0] vcc_s_r;
	logic [1:0] mr_s_r;
	logic       lo_ok;
	logic       hi_ok;
	logic       vcc_ok;
	logic       mr_raw;

	always_ff @(posedge clock) begin
		if (srst) begin
			lo_s_r  <= 2'h0;
			hi_s_r  <= 2'h0;
			vcc_s_r <= 2'h0;
			mr_s_r  <= 2'h3;
		end else begin
			lo_s_r  <= {lo_s_r[0], low_level_sense_in};
			hi_s_r  <= {hi_s_r[0], high_level_sense_in};
			vcc_s_r <= {vcc_s_r[0], supply_ok_in};
			mr_s_r  <= {mr_s_r[0], manual_rst_n};
		end
	end
	assign lo_ok  = lo_s_r[1];
	assign hi_ok  = hi_s_r[1];
	assign vcc_ok = vcc_s_r[1];
	assign mr_raw = mr_s_r[1];

	// ==========================================================
	// battery flags
	// the single variant sets on the low input but releases on the high one
	logic [CNT_W-1:0] empty_cnt_r;
	logic [CNT_W-1:0] weak_cnt_r;
	logic             empty_r;
	logic             weak_r;
	logic             weak_fall;
	logic             weak_rise;

	assign weak_fall = (VARIANT == BMRS_SINGLE) ? !lo_ok : !hi_ok;
	// both variants release on the high input staying up
	assign weak_rise = hi_ok;

	always_ff @(posedge clock) begin
		if (srst) begin
			empty_r     <= 1'b1;
			empty_cnt_r <= '0;
		end else if (!lo_ok) begin
			empty_r     <= 1'b1;
			empty_cnt_r <= '0;
		end else if (empty_r) begin
			if (empty_cnt_r == BATT_LAST) begin
				empty_r     <= 1'b0;
				empty_cnt_r <= '0;
			end else begin
				empty_cnt_r <= empty_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			weak_r     <= 1'b1;
			weak_cnt_r <= '0;
		end else if (weak_fall) begin
			weak_r     <= 1'b1;
			weak_cnt_r <= '0;
		end else if (weak_r && weak_rise && (VARIANT == BMRS_SINGLE || !empty_r)) begin
			// dual variant waits for the empty timeout to finish first
			if (weak_cnt_r == BATT_LAST) begin
				weak_r     <= 1'b0;
				weak_cnt_r <= '0;
			end else begin
				weak_cnt_r <= weak_cnt_r + 1'b1;
			end
		end else begin
			weak_cnt_r <= '0; // high input must stay up the whole time
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			combined_low_batt_flag_n <= 1'b0;
			weak_batt_flag_n         <= 1'b0;
			empty_batt_flag_n        <= 1'b0;
		end else begin
			combined_low_batt_flag_n <= (VARIANT == BMRS_SINGLE) ? !weak_r : 1'b1;
			weak_batt_flag_n         <= (VARIANT == BMRS_DUAL) ? !weak_r : 1'b1;
			empty_batt_flag_n        <= (VARIANT == BMRS_DUAL) ? !empty_r : 1'b1;
		end
	end

	// ==========================================================
	// manual reset debounce: a new level is accepted only once stable
	// the far side leaves the input high when idle
	logic [CNT_W-1:0] deb_cnt_r;
	logic             mr_level_r;
	logic             mr_fire;

	always_ff @(posedge clock) begin
		if (srst) begin
			mr_level_r <= 1'b1;
			deb_cnt_r  <= '0;
		end else if (mr_raw == mr_level_r) begin
			deb_cnt_r <= '0;
		end else if (deb_cnt_r == DEB_LAST) begin
			mr_level_r <= mr_raw;
			deb_cnt_r  <= '0;
		end else begin
			deb_cnt_r <= deb_cnt_r + 1'b1;
		end
	end
	assign mr_fire = mr_level_r && !mr_raw && deb_cnt_r == DEB_LAST;

	// ==========================================================
	// manual one-shot pulse; retriggers only after release is debounced
	logic [CNT_W-1:0] mr_cnt_r;
	logic             mr_pulse_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			mr_pulse_r <= 1'b0;
			mr_cnt_r   <= '0;
		end else if (mr_fire) begin
			mr_pulse_r <= 1'b1;
			mr_cnt_r   <= '0;
		end else if (mr_pulse_r) begin
			if (mr_cnt_r == MR_LAST) begin
				mr_pulse_r <= 1'b0;
			end else begin
				mr_cnt_r <= mr_cnt_r + 1'b1;
			end
		end
	end

	// ==========================================================
	// supply supervisor
	bmrs_pwr_type     pwr_r;
	logic [CNT_W-1:0] rst_cnt_r;

	always_ff @(posedge clock) begin
		if (srst) begin
			pwr_r     <= BMRS_PWR_LOW;
			rst_cnt_r <= '0;
		end else if (!vcc_ok) begin
			pwr_r     <= BMRS_PWR_LOW;
			rst_cnt_r <= '0;
		end else begin
			unique case (pwr_r)
				BMRS_PWR_LOW: begin
					pwr_r <= BMRS_PWR_WAIT;
				end
				BMRS_PWR_WAIT: begin
					if (rst_cnt_r == RST_LAST) begin
						pwr_r <= BMRS_PWR_OK;
					end else begin
						rst_cnt_r <= rst_cnt_r + 1'b1;
					end
				end
				BMRS_PWR_OK: begin
					pwr_r <= BMRS_PWR_OK;
				end
				default: begin
					pwr_r <= BMRS_PWR_LOW;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			host_rst_n <= 1'b0;
		end else begin
			host_rst_n <= (pwr_r == BMRS_PWR_OK) && vcc_ok && !mr_pulse_r && !mr_fire;
		end
	end

	// ==========================================================
	// checks
	a_supply_low_reset: assert property (@(posedge clock) disable iff (srst)
		!vcc_ok |=> !host_rst_n)
		else $error("reset not asserted while supply low");

	sequence s_empty_up;
		empty_r ##1 !empty_batt_flag_n;
	endsequence
	a_empty_sets_flag: assert property (@(posedge clock) disable iff (srst)
		(VARIANT == BMRS_DUAL) && !lo_ok |=> s_empty_up)
		else $error("empty flag not asserted");

	a_weak_after_empty: assert property (@(posedge clock) disable iff (srst)
		(VARIANT == BMRS_DUAL) && $fell(weak_r) |-> !empty_r && !$past(empty_r))
		else $error("weak released before empty timeout done");

	a_empty_full_time: assert property (@(posedge clock) disable iff (srst)
		$fell(empty_r) |-> $past(empty_cnt_r) == BATT_LAST)
		else $error("empty flag released early");

	a_weak_full_time: assert property (@(posedge clock) disable iff (srst)
		$fell(weak_r) |-> $past(weak_cnt_r) == BATT_LAST && $past(weak_rise))
		else $error("weak flag released early");

	a_reset_full_time: assert property (@(posedge clock) disable iff (srst)
		$changed(pwr_r) && pwr_r == BMRS_PWR_OK |-> $past(rst_cnt_r) == RST_LAST)
		else $error("reset released before timeout");

	a_dip_restarts: assert property (@(posedge clock) disable iff (srst)
		pwr_r == BMRS_PWR_WAIT && !vcc_ok |=> rst_cnt_r == '0 && pwr_r == BMRS_PWR_LOW)
		else $error("reset timer not restarted");

	sequence s_mr_press;
		mr_fire;
	endsequence
	sequence s_mr_low;
		!host_rst_n [*8];
	endsequence
	a_manual_pulse: assert property (@(posedge clock) disable iff (srst)
		s_mr_press |=> s_mr_low)
		else $error("manual reset pulse missing");

	a_debounce_stable: assert property (@(posedge clock) disable iff (srst)
		$changed(mr_level_r) |-> $past(deb_cnt_r) == DEB_LAST)
		else $error("manual reset level changed without debounce");
endmodule : bmrs_top

// ### testbench/bmrs_host_model.sv
// host side model: counts and times the reset pulses it receives
`timescale 1ns/1ps
module bmrs_host_model (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        host_rst_n,
	output logic      [7:0]  pulse_cnt,
	output logic      [15:0] low_len
);
	logic [15:0] run_r;
	// ==========================================================
	// each low stretch is one restart of the host
	always_ff @(posedge clock) begin
		if (srst) begin
			run_r     <= 16'h0000;
			pulse_cnt <= 8'h00;
			low_len   <= 16'h0000;
		end else if (!host_rst_n) begin
			run_r <= run_r + 16'h0001;
		end else begin
			if (run_r != 16'h0000) begin
				pulse_cnt <= pulse_cnt + 8'h01;
				low_len   <= run_r;
			end
			run_r <= 16'h0000;
		end
	end
endmodule : bmrs_host_model

// ### testbench/tb_top.sv
// self-checking bench for the battery monitor and reset supervisor
`timescale 1ns/1ps
module tb_top;
	import bmrs_pkg::*;
	localparam int BC = 20;
	localparam int SC = 30;
	localparam int LC = 60;
	localparam int MC = 20;
	localparam int DC = 4;
	logic        clock = 1'b0;
	logic        srst  = 1'b1;
	logic        lo    = 1'b0;
	logic        hi    = 1'b0;
	logic        sup   = 1'b0;
	logic        mr    = 1'b1;
	logic        fc, wk, em, hr, fc_s, wk_s, em_s, hr_s;
	logic [7:0]  pc;
	logic [15:0] ll;
	int          err_total = 0;
	int          checked = 0;
	int          n, m, k, p0;
	always #20 clock = ~clock;
	bmrs_top #(.VARIANT(BMRS_DUAL), .BATT_CYC(BC), .SHORT_CYC(SC), .LONG_CYC(LC),
		.MR_CYC(MC), .DEB_CYC(DC)) i_bmrs_top (.clock(clock), .srst(srst),
		.low_level_sense_in(lo), .high_level_sense_in(hi), .supply_ok_in(sup),
		.manual_rst_n(mr), .combined_low_batt_flag_n(fc), .weak_batt_flag_n(wk),
		.empty_batt_flag_n(em), .host_rst_n(hr));
	// the single variant also carries the long reset timeout option
	bmrs_top #(.VARIANT(BMRS_SINGLE), .TIMEOUT_OPTION(BMRS_LONG_TIMEOUT), .BATT_CYC(BC),
		.SHORT_CYC(SC), .LONG_CYC(LC), .MR_CYC(MC), .DEB_CYC(DC)) i_bmrs_top_single (
		.clock(clock), .srst(srst), .low_level_sense_in(lo), .high_level_sense_in(hi),
		.supply_ok_in(sup), .manual_rst_n(mr), .combined_low_batt_flag_n(fc_s),
		.weak_batt_flag_n(wk_s), .empty_batt_flag_n(em_s), .host_rst_n(hr_s));
	bmrs_host_model i_bmrs_host_model (.clock(clock), .srst(srst), .host_rst_n(hr),
		.pulse_cnt(pc), .low_len(ll));
	task automatic tally_and_finish();
		if (err_total == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %b seen %b", what, exp, got);
			err_total++;
		end
	endtask : chk_bit
	task automatic chk_rng(input string what, input int lo_b, input int hi_b,
		input logic [31:0] got);
		checked++;
		if ($isunknown(got) || got < lo_b || got > hi_b) begin
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo_b, hi_b, got);
			err_total++;
		end
	endtask : chk_rng
	function automatic logic pick(input int sel);
		case (sel)
			0: return hr;
			1: return em;
			2: return wk;
			3: return fc_s;
			default: return hr_s;
		endcase
	endfunction : pick
	// bounded wait for an output to read high, in cycles
	task automatic wait_rise(input int sel, output int cnt);
		cnt = 0;
		while (pick(sel) !== 1'b1) begin
			@(negedge clock);
			cnt++;
			if (cnt > 400) begin
				$display("wrong value wait expected 1 seen %b", pick(sel));
				err_total++;
				tally_and_finish();
			end
		end
	endtask : wait_rise
	task automatic t_powerup();
		@(negedge clock);
		chk_bit("reset", 1'b0, hr);
		chk_bit("empty", 1'b0, em);
		chk_bit("weak", 1'b0, wk);
		chk_bit("combined", 1'b0, fc_s);
		chk_bit("unused combined", 1'b1, fc);
		chk_bit("unused weak", 1'b1, wk_s);
		chk_bit("unused empty", 1'b1, em_s);
	endtask : t_powerup
	task automatic t_supply();
		sup = 1'b1;
		repeat (15) @(negedge clock);
		sup = 1'b0;
		repeat (3) @(negedge clock);
		sup = 1'b1;
		wait_rise(0, n);
		chk_rng("short release", SC, SC + 8, n);
		wait_rise(4, m);
		chk_rng("long release", LC, LC + 8, n + m);
		sup = 1'b0;
		repeat (6) @(negedge clock);
		chk_bit("supply low reset", 1'b0, hr);
		sup = 1'b1;
		wait_rise(0, n);
	endtask : t_supply
	task automatic t_batt();
		lo = 1'b1;
		hi = 1'b1;
		wait_rise(3, k);
		chk_rng("combined release", BC, BC + 8, k);
		wait_rise(1, n);
		chk_rng("empty release", BC, BC + 8, k + n);
		wait_rise(2, m);
		chk_rng("weak release", 2 * BC, 2 * BC + 12, k + n + m);
		hi = 1'b0;
		repeat (6) @(negedge clock);
		chk_bit("weak set", 1'b0, wk);
		chk_bit("empty held", 1'b1, em);
		chk_bit("combined held", 1'b1, fc_s);
		lo = 1'b0;
		repeat (6) @(negedge clock);
		chk_bit("empty set", 1'b0, em);
		chk_bit("combined set", 1'b0, fc_s);
	endtask : t_batt
	task automatic t_manual();
		p0 = pc;
		mr = 1'b0;
		repeat (2) @(negedge clock);
		mr = 1'b1;
		repeat (10) @(negedge clock);
		chk_rng("glitch pulses", p0, p0, pc);
		chk_bit("glitch reset", 1'b1, hr);
		mr = 1'b0;
		repeat (40) @(negedge clock);
		chk_bit("pulse one-shot", 1'b1, hr);
		mr = 1'b1;
		repeat (2) @(negedge clock);
		mr = 1'b0;
		repeat (2) @(negedge clock);
		mr = 1'b1;
		repeat (30) @(negedge clock);
		chk_rng("pulse count", p0 + 1, p0 + 1, pc);
		chk_rng("pulse length", MC, MC + 2, ll);
	endtask : t_manual
	initial begin
		repeat (12) @(negedge clock);
		srst = 1'b0;
		t_powerup();
		t_supply();
		t_batt();
		t_manual();
		tally_and_finish();
	end
endmodule : tb_top
